// ===== design/dac_ctrl_consts.svh
/*
  Register offsets, field positions and reset values of the reference and sleep control bank.
  Assumes inclusion by the design module, the checker and the testbench only.
*/
`ifndef DAC_CTRL_CONSTS_SVH
`define DAC_CTRL_CONSTS_SVH
`define ADDR_VOL_REF      5'h08
`define ADDR_VOL_SLEEP    5'h09
`define ADDR_VOL_GAIN     5'h0A
`define ADDR_NV_REF       5'h18
`define ADDR_NV_SLEEP     5'h19
`define ADDR_NV_GAIN      5'h1A
`define CH0_FIELD_LSB     0
`define CH1_FIELD_LSB     2
`define GAIN_FIELD_LSB    8
`define CTRL_RESET        4'h0
`define GAIN_RESET        2'h0
`define REF_SUPPLY        2'h0
`define REF_BANDGAP       2'h1
`define REF_PIN_DIRECT    2'h2
`define REF_PIN_BUFFERED  2'h3
`define SLEEP_NORMAL      2'h0
`define SLEEP_LOAD_1K     2'h1
`define SLEEP_LOAD_100K   2'h2
`define SLEEP_OPEN        2'h3
`endif

// ===== design/dac_ctrl_pkg.sv
/*
  Types shared by the reference and sleep control bank.
  Assumes dac_ctrl_consts.svh is reachable on the include path.
*/
`default_nettype none
package dac_ctrl_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       buf_en;
    logic       bandgap_on;
    logic       sel_supply;
    logic       sel_pin;
    logic       unity_gain;
    logic       powered_down;
    logic       load_1k;
    logic       load_100k;
  } ch_ctrl_t;
endpackage : dac_ctrl_pkg
`default_nettype wire

// ===== design/dac_ref_powerdown_ctrl_regs.sv
/*
  Reference-select and sleep control registers (volatile and nonvolatile copies)
  of a one- or two-channel DAC, with decoded per-channel analog controls.
  Assumes a serial-bus front end delivers one-cycle register read and write requests
  synchronous to CLOCK, and that nonvolatile storage timing is handled elsewhere.
*/
// Functional notes
// - Reference select register holds two source bits per channel, channel 1 above.
// - Code 11 picks the reference pin buffered; code 10 picks it unbuffered.
// - Code 01 picks the internal band gap, buffer on, driven in sleep.
// - Code 00 picks the supply rail, unbuffered; lowest current with sleep.
// - Band gap keeps driving the reference pin in every sleep mode.
// - Codes 00 and 10 switch the band gap circuitry off.
// - Sleep register holds two bits per channel, channel 1 in the upper pair.
// - Sleep 00 normal, 01 1k to ground, 10 100k to ground, 11 open.
// - Unused upper bits of both control registers read as zero.
// - Implemented width is two bits times the channel count.
// - Sleep control exists as volatile at 09h and nonvolatile at 19h.
// - Supply-rail reference forces unity gain regardless of the gain bit.
`timescale 1ns/1ns
`default_nettype none
`include "dac_ctrl_consts.svh"

module dac_ref_powerdown_ctrl_regs
  import dac_ctrl_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire reg_req_t    REQ,
  input  wire logic [1:0]  GAIN_BITS,
  output var  logic [15:0] RDATA,
  output var  logic        RVALID,
  output var  ch_ctrl_t    CH0_CTRL,
  output var  ch_ctrl_t    CH1_CTRL
);

  localparam logic [3:0] IMPL_MASK = (CHANNELS == 2) ? 4'hF : 4'h3;

  logic [3:0]  vol_ref, vol_sleep, nv_ref, nv_sleep;
  logic [3:0]  next_vol_ref, next_vol_sleep, next_nv_ref, next_nv_sleep;
  logic [15:0] next_rdata;
  logic        next_rvalid;
  ch_ctrl_t    next_ctrl [2];
  ch_ctrl_t    ctrl      [2];

  // ***************************************************************
  // Address decode
  // ***************************************************************
  function automatic logic is_ctrl(input logic [4:0] a, input logic [4:0] target);
    return a == target;
  endfunction : is_ctrl

  // ***************************************************************
  // Register file
  // ***************************************************************
  // Upper bits are masked at write, so they can never hold a one.
  always_comb begin
    next_vol_ref   = vol_ref;
    next_vol_sleep = vol_sleep;
    next_nv_ref    = nv_ref;
    next_nv_sleep  = nv_sleep;
    if (REQ.wr) begin
      if (is_ctrl(REQ.addr, `ADDR_VOL_REF))
        next_vol_ref = REQ.wdata[3:0] & IMPL_MASK;
      if (is_ctrl(REQ.addr, `ADDR_VOL_SLEEP))
        next_vol_sleep = REQ.wdata[3:0] & IMPL_MASK;
      if (is_ctrl(REQ.addr, `ADDR_NV_REF))
        next_nv_ref = REQ.wdata[3:0] & IMPL_MASK;
      if (is_ctrl(REQ.addr, `ADDR_NV_SLEEP))
        next_nv_sleep = REQ.wdata[3:0] & IMPL_MASK;
    end
  end

  always_comb begin
    next_rdata  = 16'h0000;
    next_rvalid = REQ.rd;
    if (REQ.rd) begin
      case (REQ.addr)
        `ADDR_VOL_REF:   next_rdata = {12'h000, vol_ref};
        `ADDR_VOL_SLEEP: next_rdata = {12'h000, vol_sleep};
        `ADDR_NV_REF:    next_rdata = {12'h000, nv_ref};
        `ADDR_NV_SLEEP:  next_rdata = {12'h000, nv_sleep};
        default:         next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      vol_ref   <= `CTRL_RESET;
      vol_sleep <= `CTRL_RESET;
      nv_ref    <= `CTRL_RESET;
      nv_sleep  <= `CTRL_RESET;
      RDATA     <= 16'h0000;
      RVALID    <= 1'b0;
    end else begin
      vol_ref   <= next_vol_ref;
      vol_sleep <= next_vol_sleep;
      nv_ref    <= next_nv_ref;
      nv_sleep  <= next_nv_sleep;
      RDATA     <= next_rdata;
      RVALID    <= next_rvalid;
    end
  end

  // ***************************************************************
  // Per-channel analog control decode
  // ***************************************************************
  // The live controls follow the volatile copy; the nonvolatile copy only
  // seeds it at power-up, which the storage controller does by a write.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [1:0] rsel, slp;
      logic       present;
      assign present = (ch < CHANNELS);
      assign rsel    = vol_ref[2*ch +: 2];
      assign slp     = vol_sleep[2*ch +: 2];
      always_comb begin
        next_ctrl[ch] = '0;
        if (present) begin
          case (rsel)
            `REF_PIN_BUFFERED: begin
              next_ctrl[ch].sel_pin = 1'b1;
              next_ctrl[ch].buf_en  = 1'b1;
            end
            `REF_PIN_DIRECT: begin
              next_ctrl[ch].sel_pin = 1'b1;
            end
            `REF_BANDGAP: begin
              // Band gap stays on even in sleep so the reference pin is driven.
              next_ctrl[ch].bandgap_on = 1'b1;
              next_ctrl[ch].buf_en     = 1'b1;
            end
            default: begin
              next_ctrl[ch].sel_supply = 1'b1;
            end
          endcase
          next_ctrl[ch].unity_gain = (rsel == `REF_SUPPLY) | ~GAIN_BITS[ch];
          case (slp)
            `SLEEP_NORMAL:    next_ctrl[ch].powered_down = 1'b0;
            `SLEEP_LOAD_1K: begin
              next_ctrl[ch].powered_down = 1'b1;
              next_ctrl[ch].load_1k      = 1'b1;
            end
            `SLEEP_LOAD_100K: begin
              next_ctrl[ch].powered_down = 1'b1;
              next_ctrl[ch].load_100k    = 1'b1;
            end
            default:          next_ctrl[ch].powered_down = 1'b1;
          endcase
        end
      end

      always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          ctrl[ch] <= '0;
        end else begin
          ctrl[ch] <= next_ctrl[ch];
        end
      end
    end
  endgenerate

  assign CH0_CTRL = ctrl[0];
  assign CH1_CTRL = ctrl[1];

endmodule : dac_ref_powerdown_ctrl_regs
`default_nettype wire

// ===== verif/dac_ctrl_monitor.sv
/* Port checker for the control bank.
   Assumes CH outputs follow a write two edges after the request. */
`timescale 1ns/1ns
`default_nettype none
`include "dac_ctrl_consts.svh"
module dac_ctrl_monitor
  import dac_ctrl_pkg::*;
#(parameter int CHANNELS = 2) (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire reg_req_t    REQ,
  input wire logic [1:0]  GAIN_BITS,
  input wire logic [15:0] RDATA,
  input wire logic        RVALID,
  input wire ch_ctrl_t    CH0_CTRL,
  input wire ch_ctrl_t    CH1_CTRL
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  wire logic wref = REQ.wr && REQ.addr == `ADDR_VOL_REF;
  wire logic wslp = REQ.wr && REQ.addr == `ADDR_VOL_SLEEP;
  property p_rv; REQ.rd |=> RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_hi; RVALID |-> (RDATA >> (2 * CHANNELS)) == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_bg; wref && REQ.wdata[1:0] == 2'h1 |=> ##1 CH0_CTRL.bandgap_on && CH0_CTRL.buf_en;
  endproperty
  a_bg: assert property (p_bg) else $error("band gap decode");
  property p_off; wref && !REQ.wdata[0] |=> ##1 !CH0_CTRL.bandgap_on; endproperty
  a_off: assert property (p_off) else $error("band gap not off");
  property p_buf; wref && REQ.wdata[1:0] == 2'h3 |=> ##1 CH0_CTRL.sel_pin && CH0_CTRL.buf_en;
  endproperty
  a_buf: assert property (p_buf) else $error("buffered pin decode");
  property p_1k; wslp && REQ.wdata[1:0] == 2'h1 |=> ##1 CH0_CTRL.load_1k && !CH0_CTRL.load_100k;
  endproperty
  a_1k: assert property (p_1k) else $error("1k load decode");
  property p_c1; wslp && REQ.wdata[3:2] == 2'h2 |=> ##1 CH1_CTRL.load_100k && CH1_CTRL.powered_down;
  endproperty
  a_c1: assert property (p_c1) else $error("channel 1 sleep");
  property p_keep; $rose(CH0_CTRL.powered_down) |-> $stable(CH0_CTRL.bandgap_on); endproperty
  a_keep: assert property (p_keep) else $error("band gap dropped in sleep");
  property p_ug; CH0_CTRL.sel_supply |-> CH0_CTRL.unity_gain; endproperty
  a_ug: assert property (p_ug) else $error("supply gain not unity");
  c_rd: cover property (REQ.rd ##1 RVALID);
  c_pd: cover property ($rose(CH0_CTRL.powered_down));
  c_ug: cover property (CH0_CTRL.sel_supply && GAIN_BITS[0]);
endmodule : dac_ctrl_monitor
bind dac_ref_powerdown_ctrl_regs dac_ctrl_monitor #(.CHANNELS(CHANNELS)) i_mon (.CLOCK(CLOCK),
  .RST(RST), .REQ(REQ), .GAIN_BITS(GAIN_BITS), .RDATA(RDATA), .RVALID(RVALID),
  .CH0_CTRL(CH0_CTRL), .CH1_CTRL(CH1_CTRL));
`default_nettype wire

// ===== verif/dac_host.sv
/* Host model issuing register requests.
   Assumes each call starts just after a falling CLOCK edge. */
`timescale 1ns/1ns
`default_nettype none
module dac_host
  import dac_ctrl_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic [15:0] RDATA,
  input  wire logic        RVALID,
  output var  reg_req_t    REQ
);
  initial REQ = '0;
  // Calls chain back to back; REQ only moves at falling edges so it is steady at rise.
  task automatic xfer(input logic w, input logic r, input logic [4:0] a,
                      input logic [15:0] d, output logic [15:0] q, output logic v);
    REQ <= '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge CLOCK);
    q = RDATA;
    v = RVALID;
  endtask : xfer
endmodule : dac_host
`default_nettype wire

// ===== verif/testbench.sv
/* Self-checking bench for the control bank.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`include "dac_ctrl_consts.svh"
module testbench;
  import dac_ctrl_pkg::*;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic [1:0]  GAIN_BITS = 2'h0;
  reg_req_t    REQ;
  logic [15:0] RDATA;
  logic [15:0] q;
  logic        RVALID;
  logic        v;
  ch_ctrl_t    CH0_CTRL;
  ch_ctrl_t    CH1_CTRL;
  int          err_count = 0;
  int          n_compared = 0;
  logic [7:0]  refx [4] = '{8'h28, 8'hC8, 8'h18, 8'h98};
  logic [7:0]  slx [4] = '{8'h00, 8'h06, 8'h05, 8'h04};
  always #5 CLOCK = ~CLOCK;
  dac_host i_dac_host (.CLOCK(CLOCK), .RDATA(RDATA), .RVALID(RVALID), .REQ(REQ));
  dac_ref_powerdown_ctrl_regs #(.CHANNELS(2)) i_dac_ref_powerdown_ctrl_regs (.CLOCK(CLOCK),
    .RST(RST), .REQ(REQ), .GAIN_BITS(GAIN_BITS), .RDATA(RDATA), .RVALID(RVALID),
    .CH0_CTRL(CH0_CTRL), .CH1_CTRL(CH1_CTRL));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    i_dac_host.xfer(1'b1, 1'b0, a, d, q, v);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    i_dac_host.xfer(1'b0, 1'b1, a, 16'h0000, q, v);
    chk("rvalid", 16'h0001, {15'h0000, v});
    chk("rdata", e, q);
  endtask : rd
  // Idles one cycle so the decoded outputs of the last write have landed.
  task automatic ctl(input logic [7:0] e0, input logic [7:0] e1);
    i_dac_host.xfer(1'b0, 1'b0, 5'h00, 16'h0000, q, v);
    chk("ch0", {8'h00, e0}, {8'h00, CH0_CTRL});
    chk("ch1", {8'h00, e1}, {8'h00, CH1_CTRL});
  endtask : ctl
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(negedge CLOCK);
    RST = 1'b0;
    ctl(8'h28, 8'h28);
    rd(`ADDR_VOL_REF, 16'h0000);
    rd(`ADDR_NV_SLEEP, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_VOL_REF, {12'hFFF, 2'(3 - c), 2'(c)});
      rd(`ADDR_VOL_REF, {12'h000, 2'(3 - c), 2'(c)});
      ctl(refx[c], refx[3 - c]);
    end
    $display("reference test done");
    wr(`ADDR_VOL_REF, 16'h0005);
    for (int s = 0; s < 4; s++) begin
      wr(`ADDR_VOL_SLEEP, {12'hFFF, 2'(3 - s), 2'(s)});
      rd(`ADDR_VOL_SLEEP, {12'h000, 2'(3 - s), 2'(s)});
      ctl(8'hC8 | slx[s], 8'hC8 | slx[3 - s]);
    end
    $display("sleep test done");
    wr(`ADDR_VOL_REF, 16'h0004);
    ctl(8'h2C, 8'hC8);
    wr(`ADDR_VOL_SLEEP, 16'h0000);
    wr(`ADDR_VOL_REF, 16'h0005);
    ctl(8'hC8, 8'hC8);
    GAIN_BITS = 2'h3;
    wr(`ADDR_VOL_REF, 16'h0004);
    ctl(8'h28, 8'hC0);
    $display("gain test done");
    wr(`ADDR_NV_REF, 16'hFFFA);
    wr(`ADDR_NV_SLEEP, 16'h0007);
    wr(`ADDR_VOL_GAIN, 16'hFFFF);
    rd(`ADDR_NV_REF, 16'h000A);
    rd(`ADDR_NV_SLEEP, 16'h0007);
    rd(`ADDR_VOL_GAIN, 16'h0000);
    ctl(8'h28, 8'hC0);
    $display("storage test done");
    summarize();
  end
  initial begin
    #20000;
    err_count++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
